// File: src/adcseq_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01: sixteen inputs, two banks, two sample-holds
// R02: simultaneous mode samples both banks, converts twice
// R03: one shared twelve-bit core converts everything
// R04: arbiter picks sequencer, tracks conversion source
// R05: each sequencer steps eight slots unattended
// R06: cascade joins both into sixteen-slot sequencer
// R07: max conversion count limits sequence length
// R08: first sequencer starts from four selectable triggers
// R09: second sequencer only software or pwm started
// R10: sixteen result slots hold counts until overwritten
// R11: any input may fill any slot
// R12: end of sequence pulses combined interrupt plus owning sequencer's own
// R13: sample switch closed prescale plus one cycles
// R14: reset leaves core unpowered, clock gated
// R15: last conversion returns pointer to first slot

////////////////////////////////////////////////////////////////////////////////
module adcseq_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];       // storage words
  logic [AW-1:0] wp_reg;       // write pointer
  logic [AW-1:0] rp_reg;       // read pointer
  logic [AW:0]   cnt_reg;      // fill level
  logic          push;
  logic          pop;
  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end
  // pointers and level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wp_reg <= AW'(wp_reg + 1'b1);
      if (pop) rp_reg <= AW'(rp_reg + 1'b1);
      cnt_reg <= (AW+1)'(cnt_reg + push - pop);
    end
  end
endmodule : adcseq_fifo

////////////////////////////////////////////////////////////////////////////////
module adcseq_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // trigger pins
  input  wire logic [3:0]  soc_trig,
  input  wire logic        pwm_trig,
  // converter core
  output logic             core_clk_en,
  output logic             core_pwr_up,
  output logic [2:0]       mux_a_sel,
  output logic [2:0]       mux_b_sel,
  output logic             sh_a_sample,
  output logic             sh_b_sample,
  output logic             conv_start,
  output logic             conv_sel_b,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_data,
  // end of sequence pulses
  output logic             converter_sequence_irq,
  output logic             first_sequencer_irq,
  output logic             second_sequencer_irq
);
  logic [1:0]  rst_sync_reg;            // reset release chain
  logic        rst_n;
  logic [4:0]  trig_s1_reg;             // first sync stage
  logic [4:0]  trig_s2_reg;             // second sync stage
  logic [4:0]  trig_old_reg;            // edge history
  logic [3:0]  ctrl_reg;                // clk_en, pwr, cascade, sim
  logic [3:0]  acq_reg;                 // acquisition_prescale
  logic [6:0]  maxc_reg;                // max_conversion_count
  logic [1:0]  tsel_reg;                // first sequencer trigger pick
  logic [3:0]  chan_reg [16];           // analog_input_channel per slot
  logic [11:0] conversion_result_slots [16];
  logic        pend1_reg;               // first_sequencer start pending
  logic        pend2_reg;               // second_sequencer start pending
  logic [3:0]  ptr1_reg;                // first_sequencer state pointer
  logic [2:0]  ptr2_reg;                // second_sequencer state pointer
  logic        owner_reg;               // 1 when second sequencer owns core
  logic        half_reg;                // second half of simultaneous pair
  logic [3:0]  cnt_reg;                 // acquisition counter
  logic [11:0] data_reg;                // captured count
  adcseq_pkg::adcseq_state_t state_reg;
  logic        go1;
  logic        go2;
  logic        ready;
  logic [3:0]  slot;
  logic [3:0]  chan;
  logic [3:0]  res_idx;
  logic        last;
  logic        f_in_ready;
  logic        f_out_valid;
  logic [15:0] f_out_data;
  logic        sw1;
  logic        sw2;
  logic        wr_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // trigger pins through two flops, then edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_s1_reg  <= 5'h00;
      trig_s2_reg  <= 5'h00;
      trig_old_reg <= 5'h00;
    end else begin
      trig_s1_reg  <= {pwm_trig, soc_trig};
      trig_s2_reg  <= trig_s1_reg;
      trig_old_reg <= trig_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start requests
  assign wr_ctrl = reg_wr & (reg_addr == adcseq_pkg::CTRL_OFS);
  assign sw1 = wr_ctrl & reg_wdata[adcseq_pkg::SW1_BIT];
  assign sw2 = wr_ctrl & reg_wdata[adcseq_pkg::SW2_BIT];
  // selected trigger edge or software start
  assign go1 = sw1 | (trig_s2_reg[tsel_reg] & ~trig_old_reg[tsel_reg]); // R08
  // only software or pwm edge; cascade drops these starts unserved
  assign go2 = sw2 | (trig_s2_reg[4] & ~trig_old_reg[4]); // R09
  // core usable only when clocked and powered
  assign ready = ctrl_reg[adcseq_pkg::CLK_EN_BIT] & ctrl_reg[adcseq_pkg::PWR_BIT]; // R14
  // slot in use: second sequencer owns upper half
  assign slot = owner_reg ? {1'b1, ptr2_reg} : ptr1_reg; // R04
  assign chan = chan_reg[slot]; // R11
  // simultaneous second half lands in the other bank's slot
  assign res_idx = half_reg ? (slot ^ 4'h8) : slot; // R02
  // end of list per mode
  assign last = owner_reg ? (ptr2_reg == maxc_reg[6:4]) :
                ctrl_reg[adcseq_pkg::CASC_BIT] ? (ptr1_reg == maxc_reg[3:0]) :
                (ptr1_reg[2:0] == maxc_reg[2:0]); // R07

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= adcseq_pkg::CTRL_RST; // R14
      acq_reg  <= adcseq_pkg::ACQ_RST;
      maxc_reg <= adcseq_pkg::MAXC_RST;
      tsel_reg <= 2'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        adcseq_pkg::CTRL_OFS: ctrl_reg <= reg_wdata[3:0];
        adcseq_pkg::ACQ_OFS:  acq_reg  <= reg_wdata[3:0];
        adcseq_pkg::MAXC_OFS: maxc_reg <= reg_wdata[6:0];
        adcseq_pkg::TSEL_OFS: tsel_reg <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // channel slot table
  always_ff @(posedge clk) begin
    if (reg_wr && reg_addr[5:4] == adcseq_pkg::CHAN_OFS[5:4]) begin
      chan_reg[reg_addr[3:0]] <= reg_wdata[3:0]; // R11
    end
  end

  // result slots filled from the buffer, held until overwritten
  always_ff @(posedge clk) begin
    if (f_out_valid && !reg_rd) begin
      conversion_result_slots[f_out_data[15:12]] <= f_out_data[11:0]; // R10
    end
  end

  // register read, one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr[5:4])
        2'h0: begin
          case (reg_addr)
            adcseq_pkg::CTRL_OFS: reg_rdata <= {12'h000, ctrl_reg};
            adcseq_pkg::ACQ_OFS:  reg_rdata <= {12'h000, acq_reg};
            adcseq_pkg::MAXC_OFS: reg_rdata <= {9'h000, maxc_reg};
            adcseq_pkg::TSEL_OFS: reg_rdata <= {14'h0000, tsel_reg};
            adcseq_pkg::STAT_OFS: reg_rdata <= {5'h00, pend2_reg, pend1_reg,
                                    state_reg != adcseq_pkg::ST_IDLE, ptr2_reg, 1'b0, ptr1_reg};
            default:              reg_rdata <= 16'h0000;
          endcase
        end
        2'h1:    reg_rdata <= {12'h000, chan_reg[reg_addr[3:0]]};
        2'h2:    reg_rdata <= {4'h0, conversion_result_slots[reg_addr[3:0]]};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // power and clock gate outputs follow control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_clk_en <= 1'b0;
      core_pwr_up <= 1'b0;
    end else begin
      core_clk_en <= ctrl_reg[adcseq_pkg::CLK_EN_BIT]; // R14
      core_pwr_up <= ctrl_reg[adcseq_pkg::PWR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending starts: a new trigger beats the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend1_reg <= 1'b0;
      pend2_reg <= 1'b0;
    end else begin
      if (go1) pend1_reg <= 1'b1;
      else if (state_reg == adcseq_pkg::ST_IDLE && ready) pend1_reg <= 1'b0;
      if (go2) pend2_reg <= 1'b1;
      else if (state_reg == adcseq_pkg::ST_IDLE && ready && !pend1_reg) pend2_reg <= 1'b0;
    end
  end

  // arbiter and conversion flow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= adcseq_pkg::ST_IDLE;
      owner_reg <= 1'b0;
      half_reg  <= 1'b0;
      cnt_reg   <= 4'h0;
      data_reg  <= 12'h000;
      ptr1_reg  <= 4'h0;
      ptr2_reg  <= 3'h0;
      converter_sequence_irq <= 1'b0;
      first_sequencer_irq    <= 1'b0;
      second_sequencer_irq   <= 1'b0;
    end else begin
      converter_sequence_irq <= 1'b0;
      first_sequencer_irq    <= 1'b0;
      second_sequencer_irq   <= 1'b0;
      case (state_reg)
        adcseq_pkg::ST_IDLE: begin
          cnt_reg  <= 4'h0;
          half_reg <= 1'b0;
          // first sequencer has priority
          if (ready && pend1_reg) begin
            owner_reg <= 1'b0; // R04
            state_reg <= adcseq_pkg::ST_ACQ;
          end else if (ready && pend2_reg && !ctrl_reg[adcseq_pkg::CASC_BIT]) begin
            owner_reg <= 1'b1; // R06
            state_reg <= adcseq_pkg::ST_ACQ;
          end
        end
        adcseq_pkg::ST_ACQ: begin
          // switch stays closed prescale plus one cycles
          if (cnt_reg == acq_reg) state_reg <= adcseq_pkg::ST_CONV; // R13
          else cnt_reg <= cnt_reg + 4'h1;
        end
        adcseq_pkg::ST_CONV: begin
          state_reg <= adcseq_pkg::ST_WAIT; // R03
        end
        adcseq_pkg::ST_WAIT: begin
          if (conv_done) begin
            data_reg  <= conv_data;
            state_reg <= adcseq_pkg::ST_PUSH;
          end
        end
        adcseq_pkg::ST_PUSH: begin
          // stall here while the buffer is full
          if (f_in_ready) begin
            cnt_reg <= 4'h0;
            if (ctrl_reg[adcseq_pkg::SIM_BIT] && !half_reg) begin
              half_reg  <= 1'b1; // R02
              state_reg <= adcseq_pkg::ST_CONV;
            end else begin
              half_reg <= 1'b0;
              if (last) begin
                // rewind the list for the next trigger
                if (owner_reg) ptr2_reg <= 3'h0; // R15
                else ptr1_reg <= 4'h0; // R15
                converter_sequence_irq <= 1'b1; // R12
                first_sequencer_irq    <= ~owner_reg;
                second_sequencer_irq   <= owner_reg;
                state_reg <= adcseq_pkg::ST_IDLE;
              end else begin
                // next slot without processor help
                if (owner_reg) ptr2_reg <= ptr2_reg + 3'h1; // R05
                else if (ctrl_reg[adcseq_pkg::CASC_BIT]) ptr1_reg <= ptr1_reg + 4'h1;
                else ptr1_reg <= {1'b0, ptr1_reg[2:0] + 3'h1};
                state_reg <= adcseq_pkg::ST_ACQ;
              end
            end
          end
        end
        default: state_reg <= adcseq_pkg::ST_IDLE;
      endcase
    end
  end

  // analog path controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mux_a_sel   <= 3'h0;
      mux_b_sel   <= 3'h0;
      sh_a_sample <= 1'b0;
      sh_b_sample <= 1'b0;
      conv_start  <= 1'b0;
      conv_sel_b  <= 1'b0;
    end else begin
      mux_a_sel   <= chan[2:0]; // R01
      mux_b_sel   <= chan[2:0];
      // both holds sample together in simultaneous mode
      sh_a_sample <= (state_reg == adcseq_pkg::ST_ACQ) &
                     (ctrl_reg[adcseq_pkg::SIM_BIT] | ~chan[3]); // R02
      sh_b_sample <= (state_reg == adcseq_pkg::ST_ACQ) &
                     (ctrl_reg[adcseq_pkg::SIM_BIT] | chan[3]);
      conv_start  <= (state_reg == adcseq_pkg::ST_CONV); // R03
      conv_sel_b  <= ctrl_reg[adcseq_pkg::SIM_BIT] ? half_reg : chan[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion buffer: slot index over count
  adcseq_fifo #(
    .W(adcseq_pkg::FIFO_W),
    .D(adcseq_pkg::FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (state_reg == adcseq_pkg::ST_PUSH),
    .in_ready  (f_in_ready),
    .in_data   ({res_idx, data_reg}), // R04
    .out_valid (f_out_valid),
    .out_ready (~reg_rd),
    .out_data  (f_out_data)
  );
endmodule : adcseq_top
`default_nettype wire

// File: src/adcseq_pkg.sv
package adcseq_pkg;
  // register indices on the plain port
  localparam logic [5:0] CTRL_OFS  = 6'h00; // enables, modes, soft starts
  localparam logic [5:0] ACQ_OFS   = 6'h01; // acquisition prescale
  localparam logic [5:0] MAXC_OFS  = 6'h02; // max conversion counts
  localparam logic [5:0] TSEL_OFS  = 6'h03; // first sequencer trigger select
  localparam logic [5:0] STAT_OFS  = 6'h04; // state pointers and busy
  localparam logic [5:0] CHAN_OFS  = 6'h10; // 16 channel slots
  localparam logic [5:0] RES_OFS   = 6'h20; // 16 result slots
  // control bit positions
  localparam int CLK_EN_BIT = 0;
  localparam int PWR_BIT    = 1;
  localparam int CASC_BIT   = 2;
  localparam int SIM_BIT    = 3;
  localparam int SW1_BIT    = 4;
  localparam int SW2_BIT    = 5;
  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [3:0] ACQ_RST  = 4'h6;
  localparam logic [6:0] MAXC_RST = 7'h00;
  // buffer shape
  localparam int FIFO_W = 16;
  localparam int FIFO_D = 8;
  // conversion flow
  typedef enum logic [2:0] {ST_IDLE, ST_ACQ, ST_CONV, ST_WAIT, ST_PUSH} adcseq_state_t;
endpackage : adcseq_pkg

// File: bench/adcseq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////
module adcseq_checker (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // register writes
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  // core side
  input  wire logic        core_clk_en,
  input  wire logic        core_pwr_up,
  input  wire logic [2:0]  mux_a_sel,
  input  wire logic        sh_a_sample,
  input  wire logic        sh_b_sample,
  input  wire logic        conv_start,
  // end of sequence pulses
  input  wire logic        converter_sequence_irq,
  input  wire logic        first_sequencer_irq,
  input  wire logic        second_sequencer_irq
);
  logic [3:0] acq_q;    // shadow of acquisition prescale
  logic       sim_q;    // shadow of simultaneous mode
  logic [4:0] open_cnt; // cycles the switch has stood closed
  wire        sh_any = sh_a_sample | sh_b_sample;
  // shadow the settings the timing depends on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acq_q <= adcseq_pkg::ACQ_RST;
      sim_q <= 1'b0;
    end else if (reg_wr && reg_addr == adcseq_pkg::ACQ_OFS) begin
      acq_q <= reg_wdata[3:0];
    end else if (reg_wr && reg_addr == adcseq_pkg::CTRL_OFS) begin
      sim_q <= reg_wdata[adcseq_pkg::SIM_BIT];
    end
  end
  // length of the current sampling window
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) open_cnt <= 5'h00;
    else if (sh_any) open_cnt <= open_cnt + 5'h01;
    else open_cnt <= 5'h00;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // switch closing and opening
  sequence s_open;
    $rose(sh_any);
  endsequence
  sequence s_close;
    $fell(sh_any);
  endsequence
  a_acq_window: assert property (s_close |-> open_cnt == {1'b0, acq_q} + 5'h01)
    else $error("sampling window length wrong");
  a_open_powered: assert property (s_open |-> core_clk_en && core_pwr_up)
    else $error("sampling while core is off");
  a_clk_follow: assert property (reg_wr && reg_addr == adcseq_pkg::CTRL_OFS |->
    ##2 {core_pwr_up, core_clk_en} == $past(reg_wdata[1:0], 2))
    else $error("core enables do not follow control");
  a_conv_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_mux_hold: assert property (sh_a_sample && $past(sh_a_sample) |-> $stable(mux_a_sel))
    else $error("selector moved while sampling");
  a_sim_pair: assert property (s_open |-> !sim_q || (sh_a_sample && sh_b_sample))
    else $error("simultaneous mode did not sample both banks");
  a_bank_single: assert property (!sim_q |-> !(sh_a_sample && sh_b_sample))
    else $error("both holds sampling outside simultaneous mode");
  a_irq_pulse: assert property (converter_sequence_irq |=> !converter_sequence_irq)
    else $error("combined interrupt longer than one cycle");
  a_irq_joined: assert property (converter_sequence_irq ==
    (first_sequencer_irq | second_sequencer_irq))
    else $error("combined interrupt out of step");
endmodule : adcseq_checker

bind adcseq_top adcseq_checker u_chk (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .core_clk_en(core_clk_en),
  .core_pwr_up(core_pwr_up), .mux_a_sel(mux_a_sel), .sh_a_sample(sh_a_sample),
  .sh_b_sample(sh_b_sample), .conv_start(conv_start),
  .converter_sequence_irq(converter_sequence_irq),
  .first_sequencer_irq(first_sequencer_irq), .second_sequencer_irq(second_sequencer_irq));
`default_nettype wire

// File: bench/adcseq_core_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////
module adcseq_core_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // conversion request
  input  wire logic        conv_start,
  input  wire logic        conv_sel_b,
  input  wire logic [2:0]  mux_a_sel,
  input  wire logic [2:0]  mux_b_sel,
  // answer speed
  input  wire logic        slow,
  // conversion answer
  output logic             conv_done,
  output logic [11:0]      conv_data
);
  logic [11:0] held;   // count being produced
  int          wait_n; // cycles left before the answer
  // one conversion at a time; the count encodes bank and channel
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_done <= 1'b0;
      conv_data <= 12'h000;
      held      <= 12'h000;
      wait_n    <= 0;
    end else if (conv_start) begin
      held      <= {conv_sel_b, conv_sel_b ? mux_b_sel : mux_a_sel, 8'ha5};
      wait_n    <= slow ? 6 : 1;
      conv_done <= 1'b0;
    end else if (wait_n == 1) begin
      conv_done <= 1'b1;
      conv_data <= held;
      wait_n    <= 0;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~held; // released data: show the inverse
      if (wait_n > 1) wait_n <= wait_n - 1;
    end
  end
endmodule : adcseq_core_model
`default_nettype wire

// File: bench/adc_dual_autosequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////
module adc_dual_autosequencer_tb;
  logic        clk, resetn, reg_wr, reg_rd, pwm_trig, conv_done, slow; // single bits
  logic        core_clk_en, core_pwr_up, sh_a_sample, sh_b_sample, conv_start, conv_sel_b;
  logic [5:0]  reg_addr;             // register index
  logic [15:0] reg_wdata, reg_rdata; // register data
  logic [3:0]  soc_trig;             // first sequencer pins
  logic [11:0] conv_data;            // core count
  logic [2:0]  mux_a_sel, mux_b_sel; // selectors
  wire logic [2:0] irqv;             // first, second, combined
  int          err_count, checks_done;
  localparam logic [15:0] PW = 16'h0003; // clock and power on

  always #10 clk = ~clk;

  adcseq_top uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .soc_trig(soc_trig),
    .pwm_trig(pwm_trig), .core_clk_en(core_clk_en), .core_pwr_up(core_pwr_up),
    .mux_a_sel(mux_a_sel), .mux_b_sel(mux_b_sel), .sh_a_sample(sh_a_sample),
    .sh_b_sample(sh_b_sample), .conv_start(conv_start), .conv_sel_b(conv_sel_b),
    .conv_done(conv_done), .conv_data(conv_data), .converter_sequence_irq(irqv[0]),
    .first_sequencer_irq(irqv[2]), .second_sequencer_irq(irqv[1]));

  adcseq_core_model core (.clk(clk), .resetn(resetn), .conv_start(conv_start),
    .conv_sel_b(conv_sel_b), .mux_a_sel(mux_a_sel), .mux_b_sel(mux_b_sel),
    .slow(slow), .conv_done(conv_done), .conv_data(conv_data));

  ////////////////////////////////
  // verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // counted compare
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // one-cycle write
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  // one-cycle read, data looked at in the following cycle
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata);
  endtask : rd
  // gather interrupt pulses for up to n cycles
  task automatic wirq(input logic [2:0] e, input int n);
    logic [2:0] seen;
    seen = 3'h0;
    for (int i = 0; i < n && !(e != 3'h0 && seen == e); i++) begin
      @(posedge clk);
      #1 seen = seen | irqv;
    end
    chk("irq", {13'h0, e}, {13'h0, seen});
    if (e != 3'h0 && seen != e) test_done();
  endtask : wirq
  // load all slots, set length and mode, wait for the end
  task automatic run(input logic [63:0] c, input logic [6:0] m, input logic [15:0] t,
                     input logic [2:0] e);
    for (int i = 0; i < 16; i++) wr(adcseq_pkg::CHAN_OFS + 6'(i), {12'h0, c[4*i +: 4]});
    wr(adcseq_pkg::MAXC_OFS, {9'h0, m});
    wr(adcseq_pkg::CTRL_OFS, t);
    wirq(e, 600);
  endtask : run
  // results of slots lo..hi
  task automatic res(input logic [63:0] c, input int lo, input int hi);
    for (int i = lo; i <= hi; i++) rd(adcseq_pkg::RES_OFS + 6'(i), {4'h0, c[4*i +: 4], 8'ha5});
  endtask : res
  // pulse trigger pins for four cycles
  task automatic pulse(input logic [3:0] p, input logic w);
    @(posedge clk);
    soc_trig <= p;
    pwm_trig <= w;
    repeat (4) @(posedge clk);
    soc_trig <= 4'h0;
    pwm_trig <= 1'b0;
  endtask : pulse

  ////////////////////////////////
  // reset values, unmapped index, core held off
  task automatic t_reset;
    rd(adcseq_pkg::CTRL_OFS, {12'h0, adcseq_pkg::CTRL_RST});
    rd(adcseq_pkg::ACQ_OFS, {12'h0, adcseq_pkg::ACQ_RST});
    rd(adcseq_pkg::MAXC_OFS, {9'h0, adcseq_pkg::MAXC_RST});
    wr(6'h3f, 16'hffff);
    rd(6'h3f, 16'h0000);
    chk("core enables", 16'h0, {14'h0, core_pwr_up, core_clk_en});
  endtask : t_reset
  // four slots with a repeat and a bank B input, default window
  task automatic t_first_sequencer;
    run(64'h255d, 7'h03, PW | 16'h0010, 3'b101);
    res(64'h255d, 0, 3);
    rd(adcseq_pkg::STAT_OFS, 16'h0000);
  endtask : t_first_sequencer
  // both sequencers started together, then a slow pwm start
  task automatic t_both;
    run(64'h0000_007e_0000_0091, 7'h11, PW | 16'h0030, 3'b111);
    res(64'h0000_007e_0000_0091, 0, 1);
    res(64'h0000_007e_0000_0091, 8, 9);
    wr(adcseq_pkg::CHAN_OFS + 6'h08, 16'h0004);
    slow <= 1'b1;
    pulse(4'h0, 1'b1);
    wirq(3'b011, 600);
    res(64'h0000_0074_0000_0091, 8, 9);
    slow <= 1'b0;
  endtask : t_both
  // each trigger select: others ignored, chosen pin starts
  task automatic t_trig;
    wr(adcseq_pkg::MAXC_OFS, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      wr(adcseq_pkg::TSEL_OFS, 16'(s));
      pulse(~(4'h1 << s), 1'b0);
      wirq(3'b000, 60);
      pulse(4'h1 << s, 1'b0);
      wirq(3'b101, 600);
    end
  endtask : t_trig
  // ten slots across the join; second start refused
  task automatic t_casc;
    run(64'h0000_0087_6543_210f, 7'h09, PW | 16'h0014, 3'b101);
    res(64'h0000_0087_6543_210f, 0, 9);
    wr(adcseq_pkg::CTRL_OFS, PW | 16'h0024);
    wirq(3'b000, 200);
  endtask : t_casc
  // one pair from both banks, shortest window
  task automatic t_sim;
    wr(adcseq_pkg::ACQ_OFS, 16'h0000);
    run(64'h3, 7'h00, PW | 16'h0018, 3'b101);
    rd(adcseq_pkg::RES_OFS, 16'h03a5);
    rd(adcseq_pkg::RES_OFS + 6'h08, 16'h0ba5);
  endtask : t_sim

  ////////////////////////////////
  // main sequence
  initial begin
    clk = 0; resetn = 0; reg_wr = 0; reg_rd = 0; pwm_trig = 0; slow = 0;
    reg_addr = 6'h00; reg_wdata = 16'h0000; soc_trig = 4'h0;
    err_count = 0; checks_done = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_first_sequencer();
    t_both();
    t_trig();
    t_casc();
    t_sim();
    test_done();
  end
endmodule : adc_dual_autosequencer_tb
`default_nettype wire
